// ---- design/dac_cfg_pkg.sv ----
package dac_cfg_pkg;

    // Bus widths and transfer codes
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int IDX_W = 9;
    localparam int SAMPLE_W = 16;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] I_LOW_IDX = 9'h0f8;
    localparam logic [IDX_W-1:0] I_HIGH_IDX = 9'h0f9;
    localparam logic [IDX_W-1:0] Q_LOW_IDX = 9'h0fa;
    localparam logic [IDX_W-1:0] Q_HIGH_IDX = 9'h0fb;
    localparam logic [IDX_W-1:0] FORMAT_IDX = 9'h110;
    localparam logic [IDX_W-1:0] CONTROL_IDX = 9'h111;
    localparam logic [IDX_W-1:0] CONST_CTRL_IDX = 9'h0f0;
    localparam logic [IDX_W-1:0] STATUS_IDX = 9'h0f1;

    // Storage slots of the writable bytes
    localparam int REG_COUNT = 7;
    localparam int S_I_LO = 0;
    localparam int S_I_HI = 1;
    localparam int S_Q_LO = 2;
    localparam int S_Q_HI = 3;
    localparam int S_FMT = 4;
    localparam int S_CTRL = 5;
    localparam int S_CONST = 6;
    localparam logic [REG_COUNT-1:0][IDX_W-1:0] REG_IDX = {
        CONST_CTRL_IDX, CONTROL_IDX, FORMAT_IDX, Q_HIGH_IDX, Q_LOW_IDX, I_HIGH_IDX, I_LOW_IDX};

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h20;
    localparam logic [REG_COUNT-1:0][7:0] REG_RST = {
        8'h00, CTRL_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Field positions
    localparam int FMT_BIN_BIT = 7;
    localparam int FMT_RSV_HI = 6;
    localparam int CTRL_SINC_BIT = 7;
    localparam int CTRL_RSV_BIT = 6;
    localparam int CTRL_GAIN_BIT = 5;
    localparam int CTRL_PHASE_BIT = 4;
    localparam int CTRL_MOD_HI = 3;
    localparam int CTRL_MOD_LO = 2;
    localparam int CONST_EN_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_BIN_BIT = 1;

    // Modulation selections
    typedef enum logic [1:0] {
        MOD_NONE,
        MOD_FINE,
        MOD_FS4,
        MOD_FS8
    } mod_t;

endpackage

// ---- design/cfg_byte_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

module cfg_byte_reg
    import dac_cfg_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_value
);

    typedef struct packed {
        logic [7:0] value;
    } byte_state_t;

    byte_state_t st_q;
    byte_state_t st_d;

    // Whole byte stored, reserved bits included
    always_comb begin
        st_d = st_q;
        if (i_rst) begin
            st_d.value = RESET_VAL;
        end else if (i_we) begin
            st_d.value = i_wdata; // RULE_09
        end
    end

    always_ff @(posedge i_clk) begin
        st_q <= st_d;
    end

    assign o_value = st_q.value;

endmodule

`default_nettype wire

// ---- design/sample_override.sv ----
`timescale 1ns/1ps
`default_nettype none

module sample_override
    import dac_cfg_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_sample,
    input wire logic [W-1:0] i_constant,
    input wire logic i_enable,
    output logic [W-1:0] o_sample,
    output logic o_active
);

    typedef struct packed {
        logic [W-1:0] sample;
        logic active;
    } ovr_state_t;

    ovr_state_t st_q;
    ovr_state_t st_d;

    // Constant replaces the stream while enabled
    always_comb begin
        st_d = st_q;
        if (i_rst) begin
            st_d = '0;
        end else begin
            st_d.active = i_enable;
            st_d.sample = i_enable ? i_constant : i_sample; // RULE_10
        end
    end

    always_ff @(posedge i_clk) begin
        st_q <= st_d;
    end

    assign o_sample = st_q.sample;
    assign o_active = st_q.active;

    constant_out_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_10
        i_enable |=> o_active && o_sample == $past(i_constant))
        else $error("constant not placed on sample output");

endmodule

`default_nettype wire

// ---- design/dac_datapath_config_regs.sv ----
// Notes on behaviour
// (RULE_01) I constant upper byte, read/write, resets zero
// (RULE_02) I constant lower byte, read/write, resets zero
// (RULE_03) Q constant bytes low/high, both reset zero
// (RULE_04) Format bit 7 selects offset binary input
// (RULE_05) Control bit 7 enables sinc compensation
// (RULE_06) Control bit 5 enables gain, resets one
// (RULE_07) Control bit 4 enables phase correction
// (RULE_08) Control bits 3:2 select modulation type
// (RULE_09) Reserved bits store writes, reset zero
// (RULE_10) Constant output replaces samples while enabled
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dac_datapath_config_regs
    import dac_cfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [DATA_W-1:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [SAMPLE_W-1:0] i_i_sample,
    input wire logic [SAMPLE_W-1:0] i_q_sample,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [DATA_W-1:0] o_hrdata,
    output logic [SAMPLE_W-1:0] o_i_sample,
    output logic [SAMPLE_W-1:0] o_q_sample,
    output logic o_offset_binary,
    output logic o_sinc_compensation_enable,
    output logic o_gain_stage_enable,
    output logic o_phase_correction_enable,
    output logic [1:0] o_modulation_type,
    output logic o_constant_output_active
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic hready;
        logic hresp;
        logic [DATA_W-1:0] rdata;
        logic wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic offset_bin;
        logic sinc_en;
        logic gain_en;
        logic phase_en;
        mod_t mod_sel;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;

    logic [REG_COUNT-1:0][7:0] reg_val;
    logic [REG_COUNT-1:0] reg_we;
    logic [SAMPLE_W-1:0] i_constant_value;
    logic [SAMPLE_W-1:0] q_constant_value;
    logic constant_output_enable;
    logic i_active;
    logic q_active;
    logic [7:0] status_byte;
    logic [IDX_W-1:0] addr_idx;
    logic addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    // Write strobes at the end of a write data phase
    always_comb begin
        for (int k = 0; k < REG_COUNT; k++) begin
            reg_we[k] = st_q.wr_pend && (st_q.wr_idx == REG_IDX[k]);
        end
    end

    // One byte register per mapped slot
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_regs
        cfg_byte_reg #(
            .RESET_VAL(REG_RST[g])
        ) u_byte (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_we(reg_we[g]),
            .i_wdata(i_hwdata[7:0]),
            .o_value(reg_val[g])
        );
    end

    // Assembled 16-bit constants
    assign i_constant_value = {reg_val[S_I_HI], reg_val[S_I_LO]}; // RULE_01 RULE_02
    assign q_constant_value = {reg_val[S_Q_HI], reg_val[S_Q_LO]}; // RULE_03
    assign constant_output_enable = reg_val[S_CONST][CONST_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Sample path

    // Per channel constant override
    sample_override #(
        .W(SAMPLE_W)
    ) u_i_path (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sample(i_i_sample),
        .i_constant(i_constant_value),
        .i_enable(constant_output_enable),
        .o_sample(o_i_sample),
        .o_active(i_active)
    );

    sample_override #(
        .W(SAMPLE_W)
    ) u_q_path (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sample(i_q_sample),
        .i_constant(q_constant_value),
        .i_enable(constant_output_enable),
        .o_sample(o_q_sample),
        .o_active(q_active)
    );

    // Read-only view of the live path state
    always_comb begin
        status_byte = BYTE_ZERO;
        status_byte[STAT_ACTIVE_BIT] = i_active && q_active;
        status_byte[STAT_BIN_BIT] = st_q.offset_bin;
        status_byte[CTRL_MOD_HI:CTRL_MOD_LO] = st_q.mod_sel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave and control outputs

    // Word index of the access; higher address bits alias
    assign addr_idx = i_haddr[IDX_W+1:2];
    assign addr_ok = i_hsel && i_htrans[1] && i_hready;

    // Address phase capture, read data, datapath control flags
    always_comb begin
        logic [7:0] rd;
        logic hit;
        // Defaults: ready, OKAY, no write pending
        rd = BYTE_ZERO;
        hit = 1'b0;
        st_d = st_q;
        st_d.hready = 1'b1;
        st_d.hresp = 1'b0;
        st_d.wr_pend = 1'b0;
        // Read data from the addressed byte
        for (int k = 0; k < REG_COUNT; k++) begin
            if (addr_idx == REG_IDX[k]) begin
                rd = reg_val[k];
                hit = 1'b1;
            end
        end
        // Status byte is read-only and not a storage slot
        if (addr_idx == STATUS_IDX) begin
            rd = status_byte;
        end
        // Forward a write finishing in this same cycle
        if (hit && st_q.wr_pend && st_q.wr_idx == addr_idx) begin
            rd = i_hwdata[7:0];
        end
        // Write address phase, word size only
        if (addr_ok && i_hwrite && i_hsize == SIZE_WORD) begin
            st_d.wr_pend = 1'b1;
            st_d.wr_idx = addr_idx;
        end
        // Read data loaded at the address phase
        if (addr_ok && !i_hwrite) begin
            st_d.rdata = {{(DATA_W-8){1'b0}}, rd};
        end
        // Flags follow the stored bytes one edge later
        st_d.offset_bin = reg_val[S_FMT][FMT_BIN_BIT]; // RULE_04
        st_d.sinc_en = reg_val[S_CTRL][CTRL_SINC_BIT]; // RULE_05
        st_d.gain_en = reg_val[S_CTRL][CTRL_GAIN_BIT]; // RULE_06
        st_d.phase_en = reg_val[S_CTRL][CTRL_PHASE_BIT]; // RULE_07
        st_d.mod_sel = mod_t'(reg_val[S_CTRL][CTRL_MOD_HI:CTRL_MOD_LO]); // RULE_08
        // Reset clears all but the ready and the gain stage enable
        if (i_rst) begin
            st_d = '0;
            st_d.hready = 1'b1;
            st_d.gain_en = CTRL_RST[CTRL_GAIN_BIT]; // RULE_06
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        st_q <= st_d;
    end

    // Outputs straight from the state register; override active comes from the I path register
    assign o_hreadyout = st_q.hready;
    assign o_hresp = st_q.hresp;
    assign o_hrdata = st_q.rdata;
    assign o_offset_binary = st_q.offset_bin;
    assign o_sinc_compensation_enable = st_q.sinc_en;
    assign o_gain_stage_enable = st_q.gain_en;
    assign o_phase_correction_enable = st_q.phase_en;
    assign o_modulation_type = st_q.mod_sel;
    assign o_constant_output_active = i_active;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    i_high_write_a: assert property ( // RULE_01
        reg_we[S_I_HI] |=> i_constant_value[15:8] == $past(i_hwdata[7:0]))
        else $error("I upper constant byte not stored");

    i_low_write_a: assert property ( // RULE_02
        reg_we[S_I_LO] |=> i_constant_value[7:0] == $past(i_hwdata[7:0]))
        else $error("I lower constant byte not stored");

    q_high_write_a: assert property ( // RULE_03
        reg_we[S_Q_HI] && !reg_we[S_Q_LO]
        |=> q_constant_value[15:8] == $past(i_hwdata[7:0])
            && $stable(q_constant_value[7:0]))
        else $error("Q upper constant byte not stored");

    const_reset_a: assert property (disable iff (1'b0) // RULE_03
        i_rst |=> i_constant_value == '0 && q_constant_value == '0)
        else $error("constants not cleared by reset");

    format_flag_a: assert property ( // RULE_04
        reg_we[S_FMT] |-> ##2 o_offset_binary == $past(i_hwdata[FMT_BIN_BIT], 2))
        else $error("offset binary flag does not follow write");

    sinc_flag_a: assert property ( // RULE_05
        reg_we[S_CTRL] |-> ##2
            o_sinc_compensation_enable == $past(i_hwdata[CTRL_SINC_BIT], 2))
        else $error("sinc enable does not follow write");

    gain_reset_a: assert property (disable iff (1'b0) // RULE_06
        i_rst ##1 i_rst |-> o_gain_stage_enable && reg_val[S_CTRL] == CTRL_RST)
        else $error("gain stage not enabled after reset");

    phase_flag_a: assert property ( // RULE_07
        reg_we[S_CTRL] |-> ##2
            o_phase_correction_enable == $past(i_hwdata[CTRL_PHASE_BIT], 2))
        else $error("phase correction does not follow write");

    mod_field_a: assert property ( // RULE_08
        reg_we[S_CTRL] |-> ##2
            o_modulation_type == $past(i_hwdata[CTRL_MOD_HI:CTRL_MOD_LO], 2))
        else $error("modulation field does not follow write");

    reserved_keep_a: assert property ( // RULE_09
        reg_we[S_FMT] |=> reg_val[S_FMT][FMT_RSV_HI:0] == $past(i_hwdata[FMT_RSV_HI:0]))
        else $error("reserved format bits not kept");

    override_path_a: assert property ( // RULE_10
        constant_output_enable && $stable(i_constant_value)
        |=> o_i_sample == $past(i_constant_value))
        else $error("I constant not driven while enabled");

    read_back_a: assert property (
        addr_ok && !i_hwrite && addr_idx == CONTROL_IDX && !st_q.wr_pend
        |=> o_hrdata == {{(DATA_W-8){1'b0}}, reg_val[S_CTRL]})
        else $error("control read returned wrong data");

    always_ready_a: assert property (o_hreadyout && !o_hresp)
        else $error("slave not ready with OKAY");

    q_low_write_a: assert property ( // RULE_03
        reg_we[S_Q_LO] |=> q_constant_value[7:0] == $past(i_hwdata[7:0]))
        else $error("Q lower constant byte not stored");

    gain_flag_a: assert property ( // RULE_06
        reg_we[S_CTRL] |-> ##2
            o_gain_stage_enable == $past(i_hwdata[CTRL_GAIN_BIT], 2))
        else $error("gain enable does not follow write");

    ctrl_reserved_a: assert property ( // RULE_09
        reg_we[S_CTRL]
        |=> reg_val[S_CTRL][CTRL_RSV_BIT] == $past(i_hwdata[CTRL_RSV_BIT]))
        else $error("reserved control bit not kept");

    narrow_write_a: assert property (
        addr_ok && i_hwrite && i_hsize != SIZE_WORD |=> !st_q.wr_pend)
        else $error("write of less than a word was taken");

    // Reads: status view and a steady data bus between reads
    status_read_a: assert property (
        addr_ok && !i_hwrite && addr_idx == STATUS_IDX
        |=> o_hrdata == {{(DATA_W-8){1'b0}}, $past(status_byte)})
        else $error("status read returned wrong data");

    rdata_hold_a: assert property (
        !(addr_ok && !i_hwrite) |=> $stable(o_hrdata))
        else $error("read data changed without a read");

    // Sample path in both states of the override
    q_override_a: assert property ( // RULE_10
        constant_output_enable |=> o_q_sample == $past(q_constant_value))
        else $error("Q constant not driven while enabled");

    sample_pass_a: assert property ( // RULE_10
        !constant_output_enable
        |=> o_i_sample == $past(i_i_sample) && o_q_sample == $past(i_q_sample))
        else $error("samples not passed through while disabled");

    const_enable_a: assert property ( // RULE_10
        reg_we[S_CONST] |-> ##2
            o_constant_output_active == $past(i_hwdata[CONST_EN_BIT], 2))
        else $error("override does not follow enable write");

    // Reset values of flags, samples and bus
    format_reset_a: assert property (disable iff (1'b0) // RULE_04
        i_rst ##1 i_rst |-> !o_offset_binary && reg_val[S_FMT] == BYTE_ZERO)
        else $error("format byte not cleared by reset");

    sinc_reset_a: assert property (disable iff (1'b0) // RULE_05
        i_rst ##1 i_rst |-> !o_sinc_compensation_enable)
        else $error("sinc enable not cleared by reset");

    phase_reset_a: assert property (disable iff (1'b0) // RULE_07
        i_rst ##1 i_rst |-> !o_phase_correction_enable)
        else $error("phase correction not cleared by reset");

    mod_reset_a: assert property (disable iff (1'b0) // RULE_08
        i_rst ##1 i_rst |-> o_modulation_type == MOD_NONE)
        else $error("modulation not cleared by reset");

    sample_reset_a: assert property (disable iff (1'b0) // RULE_10
        i_rst ##1 i_rst |-> o_i_sample == '0 && o_q_sample == '0
            && !o_constant_output_active)
        else $error("samples not cleared by reset");

    bus_reset_a: assert property (disable iff (1'b0)
        i_rst ##1 i_rst |-> o_hreadyout && !o_hresp && o_hrdata == '0)
        else $error("bus outputs not at rest during reset");

    ctrl_write_c: cover property (reg_we[S_CTRL]);
    status_read_c: cover property (addr_ok && !i_hwrite && addr_idx == STATUS_IDX);
    override_on_c: cover property (o_constant_output_active);
    fs8_mod_c: cover property (o_modulation_type == MOD_FS8);
    narrow_write_c: cover property (addr_ok && i_hwrite && i_hsize != SIZE_WORD);

endmodule

`default_nettype wire

// ---- sim/test_dac_datapath_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_dac_datapath_config_regs
    import dac_cfg_pkg::*;
;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic [5:0] flags;
    } row_t;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_haddr = '0;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = SIZE_WORD;
    logic [DATA_W-1:0] i_hwdata = '0;
    logic [SAMPLE_W-1:0] i_i_sample = 16'h0000;
    logic [SAMPLE_W-1:0] i_q_sample = 16'h0000;
    logic [2:0] wsize = SIZE_WORD;
    int fails = 0;
    int checked = 0;
    wire logic o_hreadyout;
    wire logic o_hresp;
    wire logic [DATA_W-1:0] o_hrdata;
    wire logic [SAMPLE_W-1:0] o_i_sample;
    wire logic [SAMPLE_W-1:0] o_q_sample;
    wire logic o_offset_binary;
    wire logic o_sinc_compensation_enable;
    wire logic o_gain_stage_enable;
    wire logic o_phase_correction_enable;
    wire logic [1:0] o_modulation_type;
    wire logic o_constant_output_active;
    wire logic [5:0] flags;

    // Flags packed as format, sinc, gain, phase, modulation
    assign flags = {o_offset_binary, o_sinc_compensation_enable, o_gain_stage_enable,
        o_phase_correction_enable, o_modulation_type};

    // Single slave: its ready is the bus ready
    dac_datapath_config_regs dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_hsel(1'b1), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .i_i_sample(i_i_sample), .i_q_sample(i_q_sample),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
        .o_i_sample(o_i_sample), .o_q_sample(o_q_sample), .o_offset_binary(o_offset_binary),
        .o_sinc_compensation_enable(o_sinc_compensation_enable),
        .o_gain_stage_enable(o_gain_stage_enable),
        .o_phase_correction_enable(o_phase_correction_enable),
        .o_modulation_type(o_modulation_type),
        .o_constant_output_active(o_constant_output_active)
    );

    // Clock of 10 ns
    always #5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and bus tasks

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_flags(input logic [5:0] e);
        checked++;
        if (e !== flags) begin
            fails++;
            $display("wrong value flags expected %b seen %b", e, flags);
        end
    endtask

    // Wait for ready at a rising edge; only the watchdog ends a hang
    task automatic wait_ready;
        do begin
            @(posedge i_clk);
        end while (o_hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d,
        output logic [DATA_W-1:0] r);
        @(posedge i_clk);
        i_haddr <= a;
        i_hwrite <= w;
        i_hsize <= wsize;
        i_htrans <= 2'h2;
        wait_ready();
        i_htrans <= 2'h0;
        i_hwdata <= {24'h000000, d};
        wait_ready();
        r = o_hrdata;
        chk_word("ready and response", 32'h2, {30'h0, o_hreadyout, o_hresp});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [DATA_W-1:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [DATA_W-1:0] r;
        bus(a, 1'b0, 8'h00, r);
        chk_word("read data", {24'h000000, e}, r);
    endtask

    // Let one more edge land, then look off the edge
    task automatic settle;
        @(posedge i_clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence

    row_t rows [10] = '{
        '{32'h3e0, 8'ha5, 6'b001000},
        '{32'h3e4, 8'h5a, 6'b001000},
        '{32'h3e8, 8'h3c, 6'b001000},
        '{32'h3ec, 8'hc3, 6'b001000},
        '{32'h440, 8'h80, 6'b101000},
        '{32'h440, 8'h7f, 6'b001000},
        '{32'h444, 8'h80, 6'b010000},
        '{32'h444, 8'h64, 6'b001001},
        '{32'h444, 8'h18, 6'b000110},
        '{32'h444, 8'h0c, 6'b000011}
    };

    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            settle();
            chk_flags(rows[k].flags);
            rd_chk(rows[k].addr, rows[k].wdata);
        end
        // Constant override of both channels
        wr(32'h3e0, 8'h34);
        wr(32'h3e4, 8'h12);
        wr(32'h3e8, 8'hef);
        wr(32'h3ec, 8'hbe);
        i_i_sample <= 16'h1111;
        i_q_sample <= 16'h2222;
        settle();
        chk_word("i sample", 32'h1111, {16'h0, o_i_sample});
        wr(32'h3c0, 8'h01);
        settle();
        chk_word("i sample", 32'h1234, {16'h0, o_i_sample});
        chk_word("q sample", 32'hbeef, {16'h0, o_q_sample});
        chk_word("active", 32'h1, {31'h0, o_constant_output_active});
        rd_chk(32'h3c0, 8'h01);
        rd_chk(32'h3c4, 8'h0d);
        wr(32'h3e4, 8'h56);
        settle();
        chk_word("i sample", 32'h5634, {16'h0, o_i_sample});
        wr(32'h3c0, 8'h00);
        settle();
        chk_word("q sample", 32'h2222, {16'h0, o_q_sample});
        // Byte-size write is ignored, unmapped place reads zero
        wsize = 3'h0;
        wr(32'h3e0, 8'h77);
        wsize = SIZE_WORD;
        rd_chk(32'h3e0, 8'h34);
        wr(32'h100, 8'hff);
        rd_chk(32'h100, 8'h00);
        // Second reset in mid-run restores every reset value
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        settle();
        chk_flags(6'b001000);
        for (int k = 0; k < 5; k++) begin
            rd_chk(rows[k].addr, 8'h00);
        end
        rd_chk(32'h444, 8'h20);
        report_and_stop();
    end

    // Watchdog against a hung bus
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

endmodule

`default_nettype wire
